// [src/phynp_params.svh]
// constants for the next-page / mmd / energy-detect register bank
// assumes a 100 MHz mclk; included by bare name from phynp_regs only
`ifndef PHYNP_PARAMS_SVH
`define PHYNP_PARAMS_SVH

// register indices, byte address is four times the index
`define PHYNP_IDX_NP_RX 6'h08
`define PHYNP_IDX_MMD_CTL 6'h0d
`define PHYNP_IDX_MMD_AD 6'h0e
`define PHYNP_IDX_ENERGY_DETECT_POWER_DOWN_CFG 6'h10
`define PHYNP_IDX_MODE 6'h11

// field positions
`define PHYNP_NP_NEXT_BIT 15
`define PHYNP_NP_ACK_BIT 14
`define PHYNP_NP_MSG_BIT 13
`define PHYNP_NP_ACK2_BIT 12
`define PHYNP_NP_TOGGLE_BIT 11
`define PHYNP_MMD_FUNC_HI 15
`define PHYNP_MMD_FUNC_LO 14
`define PHYNP_MMD_DEV_HI 4
`define PHYNP_CFG_TXEN_BIT 15
`define PHYNP_CFG_TXIVL_LO 13
`define PHYNP_CFG_SINGLE_BIT 12
`define PHYNP_CFG_RXIVL_LO 10
`define PHYNP_CFG_INDEP_BIT 3
`define PHYNP_MODE_ENERGY_DETECT_POWER_DOWN_BIT 13

// reset values and function codes
`define PHYNP_FUNC_ADDR 2'h0
`define PHYNP_FUNC_DATA 2'h1
`define PHYNP_REG_RST 16'h0000

// timing
`define PHYNP_CLK_MHZ 100
`define PHYNP_TX_IVL0_MS 1000
`define PHYNP_TX_IVL1_MS 768
`define PHYNP_TX_IVL2_MS 512
`define PHYNP_TX_IVL3_MS 256
`define PHYNP_RX_IVL0_MS 64
`define PHYNP_RX_IVL1_MS 256
`define PHYNP_RX_IVL2_MS 512
`define PHYNP_RX_IVL3_MS 1000

`endif

// [src/phynp_pkg.sv]
// types shared by the register bank and its interval timer
// assumes phynp_params.svh is on the include path
package phynp_pkg;

	// wishbone bus-state sequencer
	typedef enum logic [1:0] {
		PHYNP_BUS_IDLE = 2'b00,
		PHYNP_BUS_MMD = 2'b01,
		PHYNP_BUS_ACK = 2'b10
	} phynp_bus_state_t;

	// classic wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} phynp_wb_req_t;

	// request into the internal mmd register space
	typedef struct packed {
		logic req;
		logic we;
		logic [4:0] dev;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [1:0] be;
	} phynp_mmd_req_t;

	// partner next page fields as captured
	typedef struct packed {
		logic next_page;
		logic message_page;
		logic ack2;
		logic toggle;
		logic [10:0] code;
	} phynp_np_t;

	// energy-detect settings kept over soft reset
	typedef struct packed {
		logic tx_en;
		logic [1:0] tx_ivl;
		logic single_wake;
		logic [1:0] rx_ivl;
		logic indep;
	} phynp_energy_detect_power_down_cfg_t;

endpackage : phynp_pkg

// [src/phynp_interval_timer.sv]
// free-running interval timer that pulses once per limit cycles
// assumes limit is at least one and changes only while stopped or between periods
`timescale 1ns/1ps
module phynp_interval_timer
	import phynp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// control
	input wire logic restart,
	input wire logic run,
	input wire logic [27:0] limit,
	// event
	output logic expired
);

	logic [27:0] count;
	logic [27:0] next_count;
	logic next_expired;

	// count up, wrap on the limit; a stopped timer sits at zero
	always_comb begin
		next_count = count;
		next_expired = 1'b0;
		if (restart || !run) begin
			next_count = 28'h0000000;
		end else if (count >= limit - 28'h0000001) begin
			next_count = 28'h0000000;
			next_expired = 1'b1;
		end else begin
			next_count = count + 28'h0000001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count <= 28'h0000000;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end

endmodule : phynp_interval_timer

// [src/phynp_regs.sv]
// next-page receive, indirect mmd access and energy-detect power-down registers
// assumes a classic wishbone master on mclk, link code words and mmd answers on mclk,
// and an asynchronous receive link pulse from the line side
//
// Functional notes
// - acknowledge bit 14 set once word arrives
// - next page, message, ack2, code fields read-only
// - toggle bit 11 shows inverse of previous
// - function field 15:14 selects address or data
// - device select 4:0 picks target mmd
// - address mode: register holds mmd address
// - data mode moves data, no increment
// - send link pulses only when power-down active
// - transmit interval 1s/768/512/256 ms
// - wake on one pulse or pulse pair
// - receive pair gap 64/256/512 ms/1s
// - independent mode or both ports down
// - kept fields survive soft reset
// - mode bit 13 enables energy-detect power-down
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "phynp_params.svh"
module phynp_regs
	import phynp_pkg::*;
#(
	parameter int unsigned MS_CYC = `PHYNP_CLK_MHZ * 1000
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// phy resets, one-cycle pulses on mclk
	input wire logic soft_rst,
	input wire logic phy_rst,
	// wishbone slave
	input wire phynp_wb_req_t wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// received link code words from auto-negotiation
	input wire logic lcw_valid,
	input wire logic [15:0] lcw_word,
	// internal mmd space
	output phynp_mmd_req_t mmd_o,
	input wire logic mmd_ack_i,
	input wire logic [15:0] mmd_rdata_i,
	// energy-detect power-down
	input wire logic energy_detect_power_down_state,
	input wire logic other_port_down,
	input wire logic rx_nlp_pin,
	output logic energy_detect_powerdown_enable,
	output logic tx_nlp,
	output logic wake
);

	localparam logic [27:0] TX_CYC0 = 28'(`PHYNP_TX_IVL0_MS * MS_CYC);
	localparam logic [27:0] TX_CYC1 = 28'(`PHYNP_TX_IVL1_MS * MS_CYC);
	localparam logic [27:0] TX_CYC2 = 28'(`PHYNP_TX_IVL2_MS * MS_CYC);
	localparam logic [27:0] TX_CYC3 = 28'(`PHYNP_TX_IVL3_MS * MS_CYC);
	localparam logic [27:0] RX_CYC0 = 28'(`PHYNP_RX_IVL0_MS * MS_CYC);
	localparam logic [27:0] RX_CYC1 = 28'(`PHYNP_RX_IVL1_MS * MS_CYC);
	localparam logic [27:0] RX_CYC2 = 28'(`PHYNP_RX_IVL2_MS * MS_CYC);
	localparam logic [27:0] RX_CYC3 = 28'(`PHYNP_RX_IVL3_MS * MS_CYC);

	// register state
	phynp_bus_state_t state, next_state;
	phynp_np_t np, next_np;
	logic np_ack, next_np_ack;
	logic [1:0] mmd_func, next_mmd_func;
	logic [4:0] mmd_device_select, next_mmd_device_select;
	logic [15:0] mmd_ad, next_mmd_ad;
	phynp_energy_detect_power_down_cfg_t cfg, next_cfg;
	logic next_energy_detect_power_down_en;
	logic [31:0] next_wb_dat;
	logic next_wb_ack;
	phynp_mmd_req_t next_mmd;

	// energy-detect state
	logic rx_sync1, rx_sync2, rx_prev;
	logic rx_edge;
	logic armed, next_armed;
	logic next_wake, next_tx_nlp;
	logic tx_active, listen;
	logic tx_expired, rx_expired;
	logic [27:0] tx_limit, rx_limit;

	// bus decode helpers
	logic hit;
	logic [5:0] idx;
	logic [15:0] rd16;
	logic [15:0] wr16;

	// merge written byte lanes over the current value
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] din,
		input logic [1:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = din[7:0];
		end
		if (be[1]) begin
			res[15:8] = din[15:8];
		end
		return res;
	endfunction : merge16

	assign hit = wb_i.cyc && wb_i.stb;
	assign idx = wb_i.adr[7:2];

	// read view of the addressed register; unmapped and reserved bits read zero
	always_comb begin
		rd16 = 16'h0000;
		if (idx == `PHYNP_IDX_NP_RX) begin
			rd16 = {np.next_page, np_ack, np.message_page, np.ack2, np.toggle, np.code};
		end else if (idx == `PHYNP_IDX_MMD_CTL) begin
			rd16 = {mmd_func, 9'h000, mmd_device_select};
		end else if (idx == `PHYNP_IDX_MMD_AD) begin
			rd16 = mmd_ad;
		end else if (idx == `PHYNP_IDX_ENERGY_DETECT_POWER_DOWN_CFG) begin
			rd16 = {cfg.tx_en, cfg.tx_ivl, cfg.single_wake, cfg.rx_ivl, 6'h00, cfg.indep, 3'h0};
		end else if (idx == `PHYNP_IDX_MODE) begin
			rd16 = {2'h0, energy_detect_powerdown_enable, 13'h0000};
		end
	end

	assign wr16 = merge16(rd16, wb_i.dat[15:0], wb_i.sel[1:0]);

	// bus sequencer, register writes, resets and next-page capture
	always_comb begin
		next_state = state;
		next_np = np;
		next_np_ack = np_ack;
		next_mmd_func = mmd_func;
		next_mmd_device_select = mmd_device_select;
		next_mmd_ad = mmd_ad;
		next_cfg = cfg;
		next_energy_detect_power_down_en = energy_detect_powerdown_enable;
		next_wb_dat = wb_dat_o;
		next_wb_ack = 1'b0;
		next_mmd = mmd_o;
		case (state)
			PHYNP_BUS_IDLE: begin
				if (hit) begin
					if (idx == `PHYNP_IDX_MMD_AD && mmd_func != `PHYNP_FUNC_ADDR) begin
						// data access goes to the stored address, which stays put
						next_mmd.req = 1'b1;
						next_mmd.we = wb_i.we;
						next_mmd.dev = mmd_device_select;
						next_mmd.addr = mmd_ad;
						next_mmd.wdata = wb_i.dat[15:0];
						next_mmd.be = wb_i.sel[1:0];
						next_state = PHYNP_BUS_MMD;
					end else begin
						next_wb_dat = {16'h0000, rd16};
						next_wb_ack = 1'b1;
						next_state = PHYNP_BUS_ACK;
						if (wb_i.we) begin
							if (idx == `PHYNP_IDX_MMD_CTL) begin
								next_mmd_func = wr16[`PHYNP_MMD_FUNC_HI:`PHYNP_MMD_FUNC_LO];
								next_mmd_device_select = wr16[`PHYNP_MMD_DEV_HI:0];
							end else if (idx == `PHYNP_IDX_MMD_AD) begin
								next_mmd_ad = wr16;
							end else if (idx == `PHYNP_IDX_ENERGY_DETECT_POWER_DOWN_CFG) begin
								next_cfg.tx_en = wr16[`PHYNP_CFG_TXEN_BIT];
								next_cfg.tx_ivl = wr16[`PHYNP_CFG_TXIVL_LO+1:`PHYNP_CFG_TXIVL_LO];
								next_cfg.single_wake = wr16[`PHYNP_CFG_SINGLE_BIT];
								next_cfg.rx_ivl = wr16[`PHYNP_CFG_RXIVL_LO+1:`PHYNP_CFG_RXIVL_LO];
								next_cfg.indep = wr16[`PHYNP_CFG_INDEP_BIT];
							end else if (idx == `PHYNP_IDX_MODE) begin
								next_energy_detect_power_down_en = wr16[`PHYNP_MODE_ENERGY_DETECT_POWER_DOWN_BIT];
							end
						end
					end
				end
			end
			PHYNP_BUS_MMD: begin
				// hold the request until the mmd space answers
				if (mmd_ack_i) begin
					next_mmd.req = 1'b0;
					next_wb_dat = {16'h0000, mmd_o.we ? 16'h0000 : mmd_rdata_i};
					next_wb_ack = 1'b1;
					next_state = PHYNP_BUS_ACK;
				end
			end
			PHYNP_BUS_ACK: begin
				next_state = PHYNP_BUS_IDLE;
			end
			default: begin
				next_state = PHYNP_BUS_IDLE;
			end
		endcase
		// soft reset clears every register field except the kept energy-detect settings; bus state and a pending mmd request run on
		if (soft_rst || phy_rst) begin
			next_np = '0;
			next_np_ack = 1'b0;
			next_mmd_func = `PHYNP_FUNC_ADDR;
			next_mmd_device_select = 5'h00;
			next_mmd_ad = `PHYNP_REG_RST;
			next_energy_detect_power_down_en = 1'b0;
		end
		if (phy_rst) begin
			next_cfg = '0;
		end
		// a word arriving alongside a reset is still captured
		if (lcw_valid) begin
			next_np.next_page = lcw_word[`PHYNP_NP_NEXT_BIT];
			next_np.message_page = lcw_word[`PHYNP_NP_MSG_BIT];
			next_np.ack2 = lcw_word[`PHYNP_NP_ACK2_BIT];
			next_np.toggle = lcw_word[`PHYNP_NP_TOGGLE_BIT];
			next_np.code = lcw_word[10:0];
			next_np_ack = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= PHYNP_BUS_IDLE;
			np <= '0;
			np_ack <= 1'b0;
			mmd_func <= `PHYNP_FUNC_ADDR;
			mmd_device_select <= 5'h00;
			mmd_ad <= `PHYNP_REG_RST;
			cfg <= '0;
			energy_detect_powerdown_enable <= 1'b0;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
			mmd_o <= '0;
		end else begin
			state <= next_state;
			np <= next_np;
			np_ack <= next_np_ack;
			mmd_func <= next_mmd_func;
			mmd_device_select <= next_mmd_device_select;
			mmd_ad <= next_mmd_ad;
			cfg <= next_cfg;
			energy_detect_powerdown_enable <= next_energy_detect_power_down_en;
			wb_dat_o <= next_wb_dat;
			wb_ack_o <= next_wb_ack;
			mmd_o <= next_mmd;
		end
	end

	// interval selection for both timers
	always_comb begin
		case (cfg.tx_ivl)
			2'h0: tx_limit = TX_CYC0;
			2'h1: tx_limit = TX_CYC1;
			2'h2: tx_limit = TX_CYC2;
			default: tx_limit = TX_CYC3;
		endcase
		case (cfg.rx_ivl)
			2'h0: rx_limit = RX_CYC0;
			2'h1: rx_limit = RX_CYC1;
			2'h2: rx_limit = RX_CYC2;
			default: rx_limit = RX_CYC3;
		endcase
	end

	// shared mode needs the other port down too; software is expected to set independent mode
	assign tx_active = cfg.tx_en && energy_detect_powerdown_enable && energy_detect_power_down_state
		&& (cfg.indep || other_port_down);
	assign listen = energy_detect_powerdown_enable && energy_detect_power_down_state;
	assign rx_edge = rx_sync2 && !rx_prev;

	phynp_interval_timer u_tx_timer (
		.mclk(mclk),
		.rstn(rstn),
		.restart(1'b0),
		.run(tx_active),
		.limit(tx_limit),
		.expired(tx_expired)
	);

	// window opens on the first pulse and closes after the selected gap
	phynp_interval_timer u_rx_timer (
		.mclk(mclk),
		.rstn(rstn),
		.restart(rx_edge),
		.run(armed),
		.limit(rx_limit),
		.expired(rx_expired)
	);

	// wake detection and pulse issue
	always_comb begin
		next_armed = armed;
		next_wake = 1'b0;
		next_tx_nlp = tx_expired && tx_active;
		if (!listen) begin
			next_armed = 1'b0;
		end else if (rx_edge) begin
			if (cfg.single_wake || armed) begin
				next_wake = 1'b1;
				next_armed = 1'b0;
			end else begin
				next_armed = 1'b1;
			end
		end else if (rx_expired) begin
			next_armed = 1'b0;
		end
	end

	// the line pulse is asynchronous, so it crosses two flops before the edge detector
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_sync1 <= 1'b0;
			rx_sync2 <= 1'b0;
			rx_prev <= 1'b0;
			armed <= 1'b0;
			wake <= 1'b0;
			tx_nlp <= 1'b0;
		end else begin
			rx_sync1 <= rx_nlp_pin;
			rx_sync2 <= rx_sync1;
			rx_prev <= rx_sync2;
			armed <= next_armed;
			wake <= next_wake;
			tx_nlp <= next_tx_nlp;
		end
	end

endmodule : phynp_regs

// [verif/phynp_regs_asserts.sv]
// port checker for the next-page / mmd / energy-detect register bank
// assumes one mclk domain and the asynchronous active-low rstn
`timescale 1ns/1ps
module phynp_regs_asserts
	import phynp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// bus and mmd side
	input wire phynp_wb_req_t wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire phynp_mmd_req_t mmd_o,
	input wire logic mmd_ack_i,
	input wire logic [15:0] mmd_rdata_i,
	// energy-detect side
	input wire logic energy_detect_power_down_state,
	input wire logic energy_detect_powerdown_enable,
	input wire logic tx_nlp,
	input wire logic wake
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// answers are single pulses, direct registers answer in the next cycle
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_direct_a: assert property ($rose(wb_i.cyc && wb_i.stb) && wb_i.adr[7:2] != 6'h0e |=> wb_ack_o)
		else $error("late answer");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper half set");
	// a pending mmd request may not move its address
	mmd_hold_a: assert property (mmd_o.req && !mmd_ack_i |=> mmd_o.req && $stable(mmd_o.addr))
		else $error("mmd request moved");
	mmd_rdata_a: assert property (mmd_o.req && mmd_ack_i && !mmd_o.we |=> wb_ack_o &&
		wb_dat_o[15:0] == $past(mmd_rdata_i)) else $error("mmd data lost");
	// pulses only while powered down, never closer than a short gap
	tx_gate_a: assert property (tx_nlp |-> $past(energy_detect_power_down_state) || $past(energy_detect_power_down_state, 2))
		else $error("pulse outside power-down");
	tx_space_a: assert property (tx_nlp |=> !tx_nlp [*8]) else $error("pulses too close");
	wake_gate_a: assert property (wake |-> $past(energy_detect_powerdown_enable)) else $error("wake while off");
	wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
	cover property (tx_nlp);
	cover property (wake);
	cover property (mmd_o.req && mmd_ack_i);
endmodule : phynp_regs_asserts

bind phynp_regs phynp_regs_asserts chk (.mclk, .rstn, .wb_i, .wb_dat_o, .wb_ack_o, .mmd_o, .mmd_ack_i,
	.mmd_rdata_i, .energy_detect_power_down_state, .energy_detect_powerdown_enable, .tx_nlp, .wake);

// [verif/phynp_far_model.sv]
// far-side model: link partner words and pulses, plus a small mmd register space
// assumes the bench seeds $urandom and calls the tasks from one process
`timescale 1ns/1ps
module phynp_far_model
	import phynp_pkg::*;
(
	// clock
	input wire logic mclk,
	// mmd space
	input wire phynp_mmd_req_t mmd_o,
	output logic mmd_ack_i,
	output logic [15:0] mmd_rdata_i,
	// cable side
	output logic lcw_valid,
	output logic [15:0] lcw_word,
	output logic rx_nlp_pin
);
	logic [15:0] mem [16];
	initial begin
		mmd_ack_i = 1'b0;
		mmd_rdata_i = 16'h0;
		lcw_valid = 1'b0;
		lcw_word = 16'h0;
		rx_nlp_pin = 1'b0;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'(16'h1111 * i);
		end
	end
	// random answer delay; read data scrambles while nothing is asked
	always @(posedge mclk) begin
		mmd_ack_i <= mmd_o.req && !mmd_ack_i && 1'($urandom_range(1));
		mmd_rdata_i <= mmd_o.req ? mem[mmd_o.addr[3:0]] : 16'($urandom);
		if (mmd_o.req && mmd_ack_i && mmd_o.we) begin
			mem[mmd_o.addr[3:0]] <= mmd_o.wdata;
		end
	end
	// one code word, then the line no longer holds it
	task send_word(input logic [15:0] w);
		@(posedge mclk);
		lcw_valid <= 1'b1;
		lcw_word <= w;
		@(posedge mclk);
		lcw_valid <= 1'b0;
		lcw_word <= ~w;
	endtask : send_word
	// link pulse long enough for the two-stage sync
	task nlp();
		@(posedge mclk);
		rx_nlp_pin <= 1'b1;
		repeat (2) @(posedge mclk);
		rx_nlp_pin <= 1'b0;
	endtask : nlp
endmodule : phynp_far_model

// [verif/test_phynp_regs.sv]
// self-checking bench for phynp_regs, one millisecond shortened to one cycle
// assumes phynp_far_model on the far side and the checker bound to uut
`timescale 1ns/1ps
module test_phynp_regs
	import phynp_pkg::*;
;
	localparam int MS = 1;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic soft_rst = 1'b0;
	logic phy_rst = 1'b0;
	logic energy_detect_power_down_state = 1'b0;
	logic other_port_down = 1'b0;
	phynp_wb_req_t wb_i = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, lcw_valid, mmd_ack_i, energy_detect_powerdown_enable, tx_nlp, wake, rx_nlp_pin;
	logic [15:0] lcw_word, mmd_rdata_i, w;
	phynp_mmd_req_t mmd_o;
	logic [16:0] q [$];
	logic [16:0] e;
	logic [7:0] adrs [6] = '{8'h20, 8'h34, 8'h38, 8'h40, 8'h44, 8'h3c};
	int tx_ms [4] = '{1000, 768, 512, 256};
	int rx_ms [4] = '{64, 256, 512, 1000};
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	always #5 mclk = ~mclk;
	phynp_regs #(.MS_CYC(MS)) uut (.mclk, .rstn, .soft_rst, .phy_rst, .wb_i, .wb_dat_o, .wb_ack_o,
		.lcw_valid, .lcw_word, .mmd_o, .mmd_ack_i, .mmd_rdata_i, .energy_detect_power_down_state, .other_port_down,
		.rx_nlp_pin, .energy_detect_powerdown_enable, .tx_nlp, .wake);
	phynp_far_model far (.mclk, .mmd_o, .mmd_ack_i, .mmd_rdata_i, .lcw_valid, .lcw_word, .rx_nlp_pin);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	// one classic cycle; the note for the answer is queued first
	task wb(input logic we, input logic [7:0] a, input logic [15:0] d, input logic [16:0] x);
		@(posedge mclk);
		wb_i <= '{1'b1, 1'b1, we, a, 4'hf, {16'h0, d}};
		q.push_back(x);
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		wb_i <= '0;
	endtask : wb
	task rst_pulse(input bit hard);
		@(posedge mclk);
		soft_rst <= !hard;
		phy_rst <= hard;
		@(posedge mclk);
		soft_rst <= 1'b0;
		phy_rst <= 1'b0;
	endtask : rst_pulse
	// cycles until tx_nlp (0) or wake (1), lim when it never comes
	task wait_ev(input bit sel, input int lim, output int k);
		for (k = 1; k < lim; k++) begin
			@(posedge mclk);
			if ((sel ? wake : tx_nlp) === 1'b1) break;
		end
	endtask : wait_ev
	// each answer takes the oldest note; writes carry no check
	always @(posedge mclk) begin
		if (wb_ack_o === 1'b1) begin
			e = q.pop_front();
			if (e[16]) check(wb_dat_o, {16'h0, e[15:0]});
		end
	end
	// every data access in this bench targets device 3 at the stored address 5
	always @(posedge mclk) begin
		if (mmd_o.req === 1'b1 && mmd_ack_i === 1'b1) check({mmd_o.dev, mmd_o.addr}, {5'h03, 16'h0005});
	end
	// hang guard, far above the longest interval sequence
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h003d426f));
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		foreach (adrs[i]) wb(1'b0, adrs[i], 16'h0, 17'h10000);
		wb(1'b1, 8'h34, 16'hffff, 17'h0);
		wb(1'b0, 8'h34, 16'h0, 17'h1c01f);
		wb(1'b1, 8'h20, 16'hffff, 17'h0);
		w = 16'($urandom);
		far.send_word(w);
		wb(1'b0, 8'h20, 16'h0, {1'b1, w | 16'h4000});
		// address mode, then every data code on one fixed address
		wb(1'b1, 8'h34, 16'h0007, 17'h0);
		wb(1'b1, 8'h38, 16'h0005, 17'h0);
		wb(1'b0, 8'h38, 16'h0, 17'h10005);
		wb(1'b1, 8'h34, 16'h4003, 17'h0);
		wb(1'b0, 8'h38, 16'h0, 17'h15555);
		wb(1'b1, 8'h38, w, 17'h0);
		for (int f = 1; f < 4; f++) begin
			wb(1'b1, 8'h34, {2'(f), 14'h3}, 17'h0);
			wb(1'b0, 8'h34, 16'h0, {1'b1, 2'(f), 14'h3});
			wb(1'b0, 8'h38, 16'h0, {1'b1, w});
		end
		// kept fields over soft reset, cleared by phy reset
		w = 16'($urandom);
		wb(1'b1, 8'h40, w, 17'h0);
		wb(1'b0, 8'h40, 16'h0, {1'b1, w & 16'hfc08});
		rst_pulse(1'b0);
		wb(1'b0, 8'h40, 16'h0, {1'b1, w & 16'hfc08});
		wb(1'b0, 8'h34, 16'h0, 17'h10000);
		rst_pulse(1'b1);
		wb(1'b0, 8'h40, 16'h0, 17'h10000);
		wb(1'b1, 8'h44, 16'h2000, 17'h0);
		wb(1'b0, 8'h44, 16'h0, 17'h12000);
		check(energy_detect_powerdown_enable, 1'b1);
		// pulse spacing for every interval code, independent mode set with enable
		for (int i = 0; i < 4; i++) begin
			energy_detect_power_down_state <= 1'b0;
			wb(1'b1, 8'h40, 16'h8008 | 16'(i << 13), 17'h0);
			energy_detect_power_down_state <= 1'b1;
			wait_ev(1'b0, 1100, n);
			wait_ev(1'b0, 1100, n);
			check(n, tx_ms[i] * MS);
		end
		energy_detect_power_down_state <= 1'b0;
		wb(1'b1, 8'h40, 16'he000, 17'h0);
		energy_detect_power_down_state <= 1'b1;
		wait_ev(1'b0, 600, n);
		check(n, 600);
		other_port_down <= 1'b1;
		wait_ev(1'b0, 600, n);
		check(n < 300, 1);
		wb(1'b1, 8'h44, 16'h0, 17'h0);
		check(energy_detect_powerdown_enable, 1'b0);
		wait_ev(1'b0, 600, n);
		check(n, 600);
		// wake on one pulse, then pairs just inside and just outside the window
		wb(1'b1, 8'h44, 16'h2000, 17'h0);
		wb(1'b1, 8'h40, 16'h1000, 17'h0);
		far.nlp();
		wait_ev(1'b1, 20, n);
		check(n < 20, 1);
		for (int j = 0; j < 4; j++) begin
			wb(1'b1, 8'h40, 16'(j << 10), 17'h0);
			far.nlp();
			repeat (rx_ms[j] * MS - 12) @(posedge mclk);
			far.nlp();
			wait_ev(1'b1, 20, n);
			check(n < 20, 1);
			far.nlp();
			repeat (rx_ms[j] * MS + 10) @(posedge mclk);
			far.nlp();
			wait_ev(1'b1, 20, n);
			check(n, 20);
			repeat (rx_ms[j] * MS + 30) @(posedge mclk);
		end
		report_and_stop();
	end
endmodule : test_phynp_regs
